// [verilog/bia_pkg.sv]
// Shared types and constants for the interrupter block
package bia_pkg;

  // Backplane inputs seen by an interrupter, all active low except the address
  typedef struct packed {
    logic as_b;
    logic ds0_b;
    logic ds1_b;
    logic lword_b;
    logic iack_b;
    logic iackin_b;
    logic write_b;
    logic [2:0] addr;
  } bia_bus_s;

  // Status/Id width codes, ordered so a larger code is a wider transfer
  typedef logic [1:0] bia_width_t;
  localparam bia_width_t BIA_W8 = 2'h0;
  localparam bia_width_t BIA_W16 = 2'h1;
  localparam bia_width_t BIA_W32 = 2'h2;

  // Data lane masks per width
  localparam logic [31:0] BIA_MASK_W8 = 32'h000000FF;
  localparam logic [31:0] BIA_MASK_W16 = 32'h0000FFFF;
  localparam logic [31:0] BIA_MASK_W32 = 32'hFFFFFFFF;

  // Release styles
  localparam logic BIA_REL_ACK = 1'b0;
  localparam logic BIA_REL_REG = 1'b1;

  // Default request level
  localparam logic [2:0] BIA_LEVEL_DEF = 3'h1;

  // Release deadlines, rounded down to whole cycles of the 100 MHz clock
  localparam int BIA_CLK_MHZ = 100;
  localparam int BIA_ACK_REL_NS = 500;
  localparam int BIA_REG_REL_US = 2;
  localparam int BIA_ACK_REL_CYC = (BIA_ACK_REL_NS * BIA_CLK_MHZ) / 1000;
  localparam int BIA_REG_REL_CYC = BIA_REG_REL_US * BIA_CLK_MHZ;

endpackage

// [verilog/bia_fall_det.sv]
// Falling edge detector for an active-low synchronous input
`timescale 1ns/1ns
`default_nettype none

module bia_fall_det
  import bia_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_sig_b,
  output logic o_fall
);

  logic prev_reg;

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prev_reg <= 1'b1;
    end else begin
      prev_reg <= i_sig_b;
    end
  end

  assign o_fall = prev_reg & ~i_sig_b;

endmodule

`default_nettype wire

// [verilog/bia_interrupter.sv]
// Interrupter: raises one request line and answers its acknowledge cycle
`timescale 1ns/1ns
`default_nettype none

module bia_interrupter
  import bia_pkg::*;
#(
  parameter logic [2:0] LEVEL = BIA_LEVEL_DEF,
  parameter bia_width_t SID_WIDTH = BIA_W8,
  parameter logic RELEASE = BIA_REL_ACK
)
(
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire bia_bus_s i_bus,
  input wire logic i_int_req,
  input wire logic [31:0] i_status_id,
  input wire logic i_reg_acc_done,
  output logic o_irq_b,
  output logic o_irq_oe_b,
  output logic o_dtack_b,
  output logic o_dtack_oe_b,
  output logic [31:0] o_data,
  output logic [31:0] o_data_oe_b,
  output logic o_iackout_b,
  output logic o_slave_ok,
  output logic o_pending
);

  localparam int ACK_MAX = BIA_ACK_REL_CYC;
  localparam int REG_MAX = BIA_REG_REL_CYC;

  typedef enum logic [2:0] {S_IDLE, S_DATA, S_ACK, S_HOLD, S_PASS} bia_state_e;

  bia_state_e state_reg;
  bia_state_e state_next;
  logic pending_reg;
  logic pending_next;
  logic reg_seen_reg;
  logic reg_seen_next;
  logic iackout_reg;
  logic dtack_on_reg;
  logic data_on_reg;
  logic [31:0] data_reg;
  logic [31:0] data_next;

  wire iackin_fall;
  wire ds0_fall;
  wire [31:0] lane_mask;
  wire both_ds_low;
  wire strobes_high;
  wire bia_width_t req_width;
  wire level_ok;
  wire width_ok;
  wire respond_ok;
  wire ack_end;
  wire ack_clr;
  wire reg_clr;

  bia_fall_det u_iackin_fall (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_sig_b(i_bus.iackin_b),
    .o_fall(iackin_fall)
  );

  bia_fall_det u_ds0_fall (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_sig_b(i_bus.ds0_b),
    .o_fall(ds0_fall)
  );

  assign lane_mask = (SID_WIDTH == BIA_W32) ? BIA_MASK_W32 :
                     (SID_WIDTH == BIA_W16) ? BIA_MASK_W16 : BIA_MASK_W8;

  assign both_ds_low = ~i_bus.ds0_b & ~i_bus.ds1_b;
  assign strobes_high = i_bus.ds0_b & i_bus.ds1_b;
  assign req_width = (both_ds_low & ~i_bus.lword_b) ? BIA_W32 :
                     both_ds_low ? BIA_W16 : BIA_W8;

  assign level_ok = (i_bus.addr == LEVEL);
  assign width_ok = (req_width >= SID_WIDTH);
  assign respond_ok = pending_reg & level_ok & width_ok & ~i_bus.iack_b;

  assign ack_end = (state_reg == S_ACK) & strobes_high;
  // release at end of own Status/Id read
  assign ack_clr = (RELEASE == BIA_REL_ACK) & ack_end;
  // release once strobe seen and access done
  assign reg_clr = (RELEASE == BIA_REL_REG) & i_reg_acc_done & reg_seen_reg;

  // new events set pending, set wins over clear
  assign pending_next = i_int_req | (pending_reg & ~(ack_clr | reg_clr));
  assign reg_seen_next = pending_next & (reg_seen_reg | (ds0_fall & i_bus.iack_b & pending_reg)) & ~reg_clr;
  assign data_next = (state_reg == S_IDLE) ? i_status_id : data_reg;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      S_IDLE: begin
        // pass the edge when not answering
        if (iackin_fall) begin
          state_next = respond_ok ? S_DATA : S_PASS;
        end
      end
      S_DATA: begin
        if (i_bus.iackin_b) begin
          state_next = S_IDLE;
        end else if (~i_bus.ds0_b) begin
          state_next = S_ACK;
        end
      end
      S_ACK: begin
        if (strobes_high) begin
          state_next = S_HOLD;
        end
      end
      S_HOLD: begin
        if (i_bus.iackin_b) begin
          state_next = S_IDLE;
        end
      end
      S_PASS: begin
        if (i_bus.iackin_b) begin
          state_next = S_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= S_IDLE;
      pending_reg <= 1'b0;
      reg_seen_reg <= 1'b0;
      iackout_reg <= 1'b1;
      dtack_on_reg <= 1'b0;
      data_on_reg <= 1'b0;
      data_reg <= 32'h00000000;
    end else begin
      state_reg <= state_next;
      pending_reg <= pending_next;
      reg_seen_reg <= reg_seen_next;
      iackout_reg <= (state_next != S_PASS);
      // data first, DTACK once the strobe is low
      data_on_reg <= (state_next == S_DATA) | (state_next == S_ACK);
      dtack_on_reg <= (state_next == S_ACK);
      data_reg <= data_next;
    end
  end

  // one request line, driven low while pending
  assign o_irq_b = 1'b0;
  assign o_irq_oe_b = ~pending_reg;
  assign o_dtack_b = 1'b0;
  assign o_dtack_oe_b = ~dtack_on_reg;
  assign o_data = data_reg;
  // lanes outside own width stay undriven
  assign o_data_oe_b = data_on_reg ? ~lane_mask : 32'hFFFFFFFF;
  assign o_iackout_b = iackout_reg;
  // board slave gated by IACK high
  assign o_slave_ok = i_bus.iack_b;
  assign o_pending = pending_reg;

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_b);

  chk_resp_cond: assert property ($fell(o_data_oe_b[0]) |-> $past(pending_reg) && $past(i_bus.addr) == LEVEL)
    else $error("Answered without pending request or matching level");

  chk_pass_edge: assert property ((state_reg == S_IDLE) && iackin_fall && !respond_ok |=> !o_iackout_b)
    else $error("Falling edge not passed down the chain");

  chk_hold_chain: assert property ((!o_dtack_oe_b || !o_data_oe_b[0]) |-> o_iackout_b)
    else $error("IACKOUT low while responding");

  chk_dtack_data: assert property ($fell(o_dtack_oe_b) |-> $past(!o_data_oe_b[0]) && !o_data_oe_b[0])
    else $error("DTACK asserted before Status/Id was on the bus");

  chk_lane_width: assert property (!o_data_oe_b[0] |-> o_data_oe_b == ~lane_mask)
    else $error("Driven data lanes do not match Status/Id width");

  chk_slave_gate: assert property (!i_bus.iack_b |-> !o_slave_ok)
    else $error("Slave enabled during acknowledge cycle");

  chk_ack_release: assert property (ack_clr && !i_int_req |-> ##[1:ACK_MAX] o_irq_oe_b)
    else $error("Request not released after Status/Id read");

  chk_reg_release: assert property (reg_clr && !i_int_req |-> ##[1:REG_MAX] o_irq_oe_b)
    else $error("Request not released after register access");

  chk_strobe_drop: assert property (ack_end |=> o_dtack_oe_b && (o_data_oe_b == 32'hFFFFFFFF) ##1 o_dtack_oe_b)
    else $error("Data or DTACK held after strobes rose");

  chk_chain_return: assert property (!o_iackout_b && i_bus.iackin_b |=> o_iackout_b)
    else $error("IACKOUT not returned high after IACKIN rose");

  chk_hold_request: assert property (!o_irq_oe_b && !$past(ack_clr) && !$past(reg_clr) |-> $past(!o_irq_oe_b) || $past(i_int_req))
    else $error("Request line changed without cause");

  chk_iackout_idle: assert property ((state_reg == S_IDLE) |-> o_iackout_b)
    else $error("IACKOUT low while idle");

  chk_data_hold: assert property (!o_dtack_oe_b |-> $stable(o_data))
    else $error("Status/Id changed while DTACK asserted");

  chk_idle_quiet: assert property ((state_reg == S_IDLE) |-> o_dtack_oe_b && (o_data_oe_b == 32'hFFFFFFFF))
    else $error("Driving the bus while idle");

  chk_pend_line: assert property (o_pending == !o_irq_oe_b)
    else $error("Request line does not follow pending state");

  chk_set_wins: assert property (i_int_req |=> o_pending)
    else $error("Event did not set pending request");

  chk_width_refuse: assert property ((state_reg == S_IDLE) && iackin_fall && !width_ok |=> o_data_oe_b == 32'hFFFFFFFF)
    else $error("Answered a narrower request than supported");

  chk_level_refuse: assert property ((state_reg == S_IDLE) && iackin_fall && !level_ok |=> !o_iackout_b)
    else $error("Level mismatch not passed down the chain");

  chk_reg_hold: assert property (o_pending && !reg_seen_reg && (RELEASE == BIA_REL_REG) |=> o_pending)
    else $error("Register-release request dropped before strobe");

  chk_ack_hold: assert property (o_pending && (state_reg != S_ACK) && (RELEASE == BIA_REL_ACK) |=> o_pending)
    else $error("Acknowledge-release request dropped early");

  chk_pass_quiet: assert property (!o_iackout_b |-> o_dtack_oe_b && o_data_oe_b[0])
    else $error("Driving the bus while passing the edge");

  chk_abort_drop: assert property (i_bus.iackin_b && (state_reg == S_DATA) |=> o_data_oe_b == 32'hFFFFFFFF)
    else $error("Data held after IACKIN rose");

  chk_upper_free: assert property ((SID_WIDTH != BIA_W32) |-> &o_data_oe_b[31:16])
    else $error("Upper data lanes driven by narrow interrupter");

  chk_slave_open: assert property (i_bus.iack_b |-> o_slave_ok)
    else $error("Slave blocked outside acknowledge");

  chk_hold_quiet: assert property ((state_reg == S_HOLD) |-> o_dtack_oe_b && o_iackout_b)
    else $error("Bus driven or chain low after answer");

  cov_answer: cover property ((state_reg == S_IDLE) && iackin_fall && respond_ok ##[1:20] !o_dtack_oe_b);
  cov_pass: cover property ((state_reg == S_IDLE) && iackin_fall && !respond_ok ##1 !o_iackout_b);
  cov_ack_release: cover property (ack_clr ##1 o_irq_oe_b);
  cov_reg_release: cover property (reg_clr ##1 o_irq_oe_b);

endmodule

`default_nettype wire

// [dv/bia_handler_model.sv]
// Handler-side model driving acknowledge and register cycles
`timescale 1ns/1ns
`default_nettype none
module bia_handler_model
  import bia_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_dtack_b,
  input wire logic [31:0] i_data,
  input wire logic i_iackout_b,
  output var bia_bus_s o_bus
);
  initial o_bus = 11'h7F8;
  task automatic iack(input logic [2:0] lvl, input bia_width_t w, output logic got, output logic [31:0] d,
                      output logic passed);
    int n;
    got = 1'b0;
    passed = 1'b0;
    d = 32'h0;
    n = 0;
    @(posedge i_core_clk);
    o_bus.addr <= lvl;
    o_bus.iack_b <= 1'b0;
    o_bus.as_b <= 1'b0;
    o_bus.iackin_b <= 1'b0;
    o_bus.ds0_b <= 1'b0;
    o_bus.ds1_b <= (w == BIA_W8);
    o_bus.lword_b <= (w != BIA_W32);
    while (!got && n < 20) begin
      @(posedge i_core_clk);
      n++;
      got = !i_dtack_b;
      passed = passed | !i_iackout_b;
      if (got) d = i_data;
    end
    o_bus <= 11'h7F8;
    repeat (3) @(posedge i_core_clk);
  endtask
  task automatic regacc();
    @(posedge i_core_clk);
    o_bus.as_b <= 1'b0;
    o_bus.ds0_b <= 1'b0;
    repeat (3) @(posedge i_core_clk);
    o_bus <= 11'h7F8;
    @(posedge i_core_clk);
  endtask
endmodule
`default_nettype wire

// [dv/bus_interrupt_ack_logic_bench.sv]
// Bench: two chained interrupters against a handler model
`timescale 1ns/1ns
`default_nettype none
module bus_interrupt_ack_logic_bench
  import bia_pkg::*;
;
  logic i_core_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic req_a = 1'b0;
  logic req_b = 1'b0;
  logic done_b = 1'b0;
  logic [31:0] sid_a = 32'hA5C37E19;
  logic [31:0] sid_b = 32'h12345666;
  bia_bus_s bus, bus_b;
  logic irq_a, dt_a, dt_b, io_a, io_b, pend_a, pend_b, got, p;
  logic [31:0] d_a, oe_a, d_b, oe_b, d;
  wire logic [31:0] dbus = (d_a | oe_a) & (d_b | oe_b);
  int failures = 0;
  int checked = 0;
  always #5 i_core_clk = ~i_core_clk;
  always_comb begin
    bus_b = bus;
    bus_b.iackin_b = io_a;
  end
  bia_handler_model bia_handler_model_i (.i_core_clk(i_core_clk), .i_dtack_b(dt_a & dt_b), .i_data(dbus),
    .i_iackout_b(io_a), .o_bus(bus));
  bia_interrupter #(.LEVEL(3'h3), .SID_WIDTH(BIA_W16), .RELEASE(BIA_REL_ACK)) bia_interrupter_i (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_bus(bus), .i_int_req(req_a), .i_status_id(sid_a),
    .i_reg_acc_done(1'b0), .o_irq_b(), .o_irq_oe_b(irq_a), .o_dtack_b(), .o_dtack_oe_b(dt_a), .o_data(d_a),
    .o_data_oe_b(oe_a), .o_iackout_b(io_a), .o_slave_ok(), .o_pending(pend_a));
  bia_interrupter #(.LEVEL(3'h5), .SID_WIDTH(BIA_W8), .RELEASE(BIA_REL_REG)) bia_interrupter_reg_i (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_bus(bus_b), .i_int_req(req_b), .i_status_id(sid_b),
    .i_reg_acc_done(done_b), .o_irq_b(), .o_irq_oe_b(), .o_dtack_b(), .o_dtack_oe_b(dt_b), .o_data(d_b),
    .o_data_oe_b(oe_b), .o_iackout_b(io_b), .o_slave_ok(), .o_pending(pend_b));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic pulse(input int which);
    @(posedge i_core_clk);
    case (which)
      0: req_a <= 1'b1;
      1: req_b <= 1'b1;
      default: done_b <= 1'b1;
    endcase
    @(posedge i_core_clk);
    req_a <= 1'b0;
    req_b <= 1'b0;
    done_b <= 1'b0;
    #1;
  endtask
  task automatic test_done();
    if (failures == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic t_reset();
    chk("pend", {pend_a, pend_b, irq_a, io_a}, 4'h3);
    chk("oe", oe_a & oe_b, 32'hFFFFFFFF);
  endtask
  task automatic t_wide();
    pulse(0);
    chk("irq", irq_a, 1'b0);
    bia_handler_model_i.iack(3'h3, BIA_W32, got, d, p);
    chk("got", got, 1'b1);
    chk("data", d, {16'hFFFF, sid_a[15:0]});
    chk("pass", p, 1'b0);
    chk("pend", pend_a, 1'b0);
  endtask
  task automatic t_refuse();
    pulse(0);
    bia_handler_model_i.iack(3'h4, BIA_W32, got, d, p);
    chk("lvl", {got, p}, 2'h1);
    bia_handler_model_i.iack(3'h3, BIA_W8, got, d, p);
    chk("wid", {got, p}, 2'h1);
    chk("hold", pend_a, 1'b1);
    bia_handler_model_i.iack(3'h3, BIA_W16, got, d, p);
    chk("data", d, {16'hFFFF, sid_a[15:0]});
    chk("pend", pend_a, 1'b0);
  endtask
  task automatic t_chain();
    pulse(1);
    bia_handler_model_i.iack(3'h5, BIA_W8, got, d, p);
    chk("chain", {got, p}, 2'h3);
    chk("data", d, {24'hFFFFFF, sid_b[7:0]});
    chk("hold", pend_b, 1'b1);
    pulse(2);
    chk("unarm", pend_b, 1'b1);
    bia_handler_model_i.regacc();
    pulse(2);
    @(posedge i_core_clk);
    #1;
    chk("rel", pend_b, 1'b0);
  endtask
  initial begin
    #200000;
    failures++;
    test_done();
  end
  initial begin
    repeat (16) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    #1;
    t_reset();
    t_wide();
    t_refuse();
    t_chain();
    test_done();
  end
endmodule
`default_nettype wire
